// File: pkg/atwf_pkg.sv
package atwf_pkg;
    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] CONTROL_OFFSET     = 8'h00;
    localparam logic [7:0] STATUS_OFFSET      = 8'h04;
    localparam logic [7:0] WORD_FORMAT_OFFSET = 8'h14;
    localparam logic [7:0] DATA_PORT_OFFSET   = 8'h20;

    // ****************************************
    // Word format fields
    // ****************************************
    localparam int          LATER_WIDTH_LSB   = 24;
    localparam int          FIRST_WIDTH_LSB   = 16;
    localparam int          FIRST_BIT_LSB     = 8;
    localparam logic [31:0] WORD_FORMAT_MASK  = 32'h1f1f1f00;
    localparam logic [31:0] WORD_FORMAT_RESET = 32'h00000000;

    // ****************************************
    // Control and status fields
    // ****************************************
    localparam int          TX_ON_BIT         = 0;
    localparam int          CHAN_ON_BIT       = 1;
    localparam int          MSB_ORDER_BIT     = 4;
    localparam int          FRAME_COUNT_BIT   = 16;
    localparam logic [31:0] CONTROL_MASK      = 32'h00010013;
    localparam logic [31:0] CONTROL_RESET     = 32'h00000000;
    localparam int          STAT_EMPTY_BIT    = 8;
    localparam int          STAT_FULL_BIT     = 9;
    localparam int          STAT_BUSY_BIT     = 10;
    localparam int          STAT_SLOT_BIT     = 11;
    localparam int          STAT_INDEX_LSB    = 16;

    // ****************************************
    // Bus encodings and sizes
    // ****************************************
    localparam logic [1:0]  HTRANS_NONSEQ     = 2'h2;
    localparam int          FIFO_DEPTH        = 8;

    typedef enum logic {
        ATWF_IDLE,
        ATWF_SHIFT
    } atwf_state_type;
endpackage : atwf_pkg

// File: rtl/atwf_top.sv
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/10ps
// How it works
// RL1: Software leaves word format alone while transmitter on is set.
// RL2: Later words use width field bits 28-24, stored as bits minus one.
// RL3: Software never programs a later word width below 8 bits.
// RL4: First word uses width field bits 20-16, stored as bits minus one.
// RL5: First word width under 8 only allowed with two words per frame.
// RL6: Every word starts shifting at first bit index, bits 12-8.
// RL7: MSB first: bit index steps down by one after each bit.
// RL8: LSB first: bit index steps up by one after each bit.
// RL9: MSB first: software sets first bit index at least the word width.
// RL10: LSB first: software sets first bit index at most 31 minus width.
// RL11: Software sets channel on before writing the data port.
// RL12: Data port write with FIFO space pushes all 32 bits. Here the push also needs channel on; with it clear the write is dropped.
// RL13: Data port write with FIFO full is dropped, FIFO untouched.
// RL14: Reserved word format bits read zero and ignore writes.
// RL15: Order bit: 0 sends LSB first, 1 sends MSB first.
// RL16: Software configures at most two words per frame.
// RL17: Data port reads return zero.
// RL18: Shifter pops one FIFO entry per word slot, width bits from first index.
module atwf_top #(
    parameter int DEPTH = atwf_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic        CORE_CLK_I,
    input  wire logic        NRST_I,
    // AHB-Lite slave
    input  wire logic        HSEL_I,
    input  wire logic [31:0] HADDR_I,
    input  wire logic [1:0]  HTRANS_I,
    input  wire logic        HWRITE_I,
    input  wire logic [2:0]  HSIZE_I,
    input  wire logic [31:0] HWDATA_I,
    input  wire logic        HREADY_I,
    output logic      [31:0] HRDATA_O,
    output logic             HREADYOUT_O,
    output logic             HRESP_O,
    // Serial link
    input  wire logic        BIT_CLK_I,
    input  wire logic        FRAME_SYNC_I,
    output logic             TX_DATA_O
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

    // ****************************************
    // Bus slave
    // ****************************************
    logic [7:0]  addr_reg,  addr_next;
    logic        wr_reg,    wr_next;
    logic        rd_reg,    rd_next;
    logic [31:0] ctrl_reg,  ctrl_next;
    logic [31:0] fmt_reg,   fmt_next;
    logic        push;
    logic [31:0] status;
    logic        fifo_full;
    logic        fifo_empty;

    always_comb begin
        addr_next = addr_reg;
        wr_next   = 1'b0;
        rd_next   = 1'b0;
        if (HSEL_I && HREADY_I && HTRANS_I[1]) begin
            // HSIZE ignored: only whole words are used
            addr_next = HADDR_I[7:0];
            wr_next   = HWRITE_I;
            rd_next   = !HWRITE_I;
        end
        ctrl_next = ctrl_reg;
        fmt_next  = fmt_reg;
        push      = 1'b0;
        if (wr_reg) begin
            unique case (addr_reg)
                atwf_pkg::CONTROL_OFFSET:     ctrl_next = HWDATA_I & atwf_pkg::CONTROL_MASK;
                // Stored as written; software keeps it still while on
                atwf_pkg::WORD_FORMAT_OFFSET: begin
                    fmt_next = HWDATA_I & atwf_pkg::WORD_FORMAT_MASK; // RL14 RL1
                end
                // Writes with channel off are dropped to keep the FIFO clean
                atwf_pkg::DATA_PORT_OFFSET: begin
                    push = !fifo_full && ctrl_reg[atwf_pkg::CHAN_ON_BIT]; // RL12 RL13 RL11
                end
                default: ;
            endcase
        end
    end

    always_comb begin
        HRDATA_O = 32'h00000000;
        if (rd_reg) begin
            unique case (addr_reg)
                atwf_pkg::CONTROL_OFFSET:     HRDATA_O = ctrl_reg;
                atwf_pkg::STATUS_OFFSET:      HRDATA_O = status;
                atwf_pkg::WORD_FORMAT_OFFSET: HRDATA_O = fmt_reg; // RL14
                default:                      HRDATA_O = 32'h00000000; // RL17
            endcase
        end
    end

    assign HREADYOUT_O = 1'b1;
    assign HRESP_O     = 1'b0;

    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            addr_reg <= 8'h00;
            wr_reg   <= 1'b0;
            rd_reg   <= 1'b0;
            ctrl_reg <= atwf_pkg::CONTROL_RESET;
            fmt_reg  <= atwf_pkg::WORD_FORMAT_RESET;
        end else begin
            addr_reg <= addr_next;
            wr_reg   <= wr_next;
            rd_reg   <= rd_next;
            ctrl_reg <= ctrl_next;
            fmt_reg  <= fmt_next;
        end
    end

    // ****************************************
    // Transmit FIFO
    // ****************************************
    logic [31:0]   mem [DEPTH];
    logic [PW-1:0] wptr_reg, wptr_next;
    logic [PW-1:0] rptr_reg, rptr_next;
    logic [CW-1:0] cnt_reg,  cnt_next;
    logic          pop;

    assign fifo_full  = (cnt_reg == DEPTH_C);
    assign fifo_empty = (cnt_reg == '0);

    always_comb begin
        wptr_next = wptr_reg;
        rptr_next = rptr_reg;
        cnt_next  = cnt_reg;
        if (push) begin
            wptr_next = (wptr_reg == PW'(DEPTH - 1)) ? '0 : wptr_reg + 1'b1; // RL12
        end
        if (pop) begin
            rptr_next = (rptr_reg == PW'(DEPTH - 1)) ? '0 : rptr_reg + 1'b1;
        end
        if (push && !pop) begin
            cnt_next = cnt_reg + 1'b1;
        end else if (pop && !push) begin
            cnt_next = cnt_reg - 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            cnt_reg  <= '0;
        end else begin
            wptr_reg <= wptr_next;
            rptr_reg <= rptr_next;
            cnt_reg  <= cnt_next;
        end
    end

    // Storage needs no reset; the empty flag from the count guards every read
    always_ff @(posedge CORE_CLK_I) begin
        if (push) begin
            mem[wptr_reg] <= HWDATA_I; // RL12
        end
    end

    // ****************************************
    // Link synchronisers
    // ****************************************
    logic [2:0] bclk_sync_reg, bclk_sync_next;
    logic [2:0] fs_sync_reg,   fs_sync_next;
    logic       bclk_fall;
    logic       fs_rise;

    always_comb begin
        bclk_sync_next = {bclk_sync_reg[1:0], BIT_CLK_I};
        fs_sync_next   = fs_sync_reg;
        if (bclk_fall) begin
            // Frame sync stage 2 takes stage 1 only on bit clock falls; stages 0 and 1 sample every cycle
            fs_sync_next = {fs_sync_reg[1], fs_sync_reg[0], FRAME_SYNC_I};
        end else begin
            fs_sync_next = {fs_sync_reg[2], fs_sync_reg[0], FRAME_SYNC_I};
        end
    end

    // Stage 0 feeds stage 1 only; edges use stages 1 and 2
    assign bclk_fall = bclk_sync_reg[2] && !bclk_sync_reg[1];
    assign fs_rise   = bclk_fall && fs_sync_reg[1] && !fs_sync_reg[2];

    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            bclk_sync_reg <= 3'h0;
            fs_sync_reg   <= 3'h0;
        end else begin
            bclk_sync_reg <= bclk_sync_next;
            fs_sync_reg   <= fs_sync_next;
        end
    end

    // ****************************************
    // Word shifter
    // ****************************************
    atwf_pkg::atwf_state_type state_reg, state_next;
    logic [31:0] word_reg,  word_next;
    logic [4:0]  idx_reg,   idx_next;
    logic [4:0]  left_reg,  left_next;
    logic        slot_reg,  slot_next;
    logic        txd_reg,   txd_next;
    logic        run;
    logic        msb_first;
    logic [4:0]  first_bit;
    logic [4:0]  first_width;
    logic [4:0]  later_width;
    logic [31:0] head;

    assign run         = ctrl_reg[atwf_pkg::TX_ON_BIT] && ctrl_reg[atwf_pkg::CHAN_ON_BIT];
    assign msb_first   = ctrl_reg[atwf_pkg::MSB_ORDER_BIT]; // RL15
    assign first_bit   = fmt_reg[atwf_pkg::FIRST_BIT_LSB +: 5]; // RL6
    assign first_width = fmt_reg[atwf_pkg::FIRST_WIDTH_LSB +: 5]; // RL4
    assign later_width = fmt_reg[atwf_pkg::LATER_WIDTH_LSB +: 5]; // RL2
    // Underrun sends zeros rather than stale data
    assign head        = fifo_empty ? 32'h00000000 : mem[rptr_reg];

    always_comb begin
        state_next = state_reg;
        word_next  = word_reg;
        idx_next   = idx_reg;
        left_next  = left_reg;
        slot_next  = slot_reg;
        txd_next   = txd_reg;
        pop        = 1'b0;
        if (!run) begin
            state_next = atwf_pkg::ATWF_IDLE;
            txd_next   = 1'b0;
        end else if (fs_rise) begin
            word_next  = head;
            pop        = !fifo_empty; // RL18
            idx_next   = first_bit; // RL6
            left_next  = first_width; // RL4
            slot_next  = 1'b0;
            txd_next   = head[first_bit];
            state_next = atwf_pkg::ATWF_SHIFT;
        end else if (bclk_fall) begin
            unique case (state_reg)
                atwf_pkg::ATWF_IDLE: begin
                    txd_next = 1'b0;
                end
                atwf_pkg::ATWF_SHIFT: begin
                    if (left_reg != 5'h00) begin
                        idx_next  = msb_first ? idx_reg - 5'h01 : idx_reg + 5'h01; // RL7 RL8
                        left_next = left_reg - 5'h01;
                        txd_next  = word_reg[idx_next];
                    end else if (!slot_reg && ctrl_reg[atwf_pkg::FRAME_COUNT_BIT]) begin
                        // Two words at most per frame
                        word_next = head; // RL16
                        pop       = !fifo_empty; // RL18
                        idx_next  = first_bit; // RL6
                        left_next = later_width; // RL2
                        slot_next = 1'b1;
                        txd_next  = head[first_bit];
                    end else begin
                        state_next = atwf_pkg::ATWF_IDLE;
                        txd_next   = 1'b0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            state_reg <= atwf_pkg::ATWF_IDLE;
            word_reg  <= 32'h00000000;
            idx_reg   <= 5'h00;
            left_reg  <= 5'h00;
            slot_reg  <= 1'b0;
            txd_reg   <= 1'b0;
        end else begin
            state_reg <= state_next;
            word_reg  <= word_next;
            idx_reg   <= idx_next;
            left_reg  <= left_next;
            slot_reg  <= slot_next;
            txd_reg   <= txd_next;
        end
    end

    assign TX_DATA_O = txd_reg;

    always_comb begin
        status                                  = 32'h00000000;
        status[CW-1:0]                          = cnt_reg;
        status[atwf_pkg::STAT_EMPTY_BIT]        = fifo_empty;
        status[atwf_pkg::STAT_FULL_BIT]         = fifo_full;
        status[atwf_pkg::STAT_BUSY_BIT]         = (state_reg == atwf_pkg::ATWF_SHIFT);
        status[atwf_pkg::STAT_SLOT_BIT]         = slot_reg;
        status[atwf_pkg::STAT_INDEX_LSB +: 5]   = idx_reg;
    end
endmodule : atwf_top

// File: dv/atwf_props.sv
`timescale 1ns/10ps
module atwf_props #(
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic        CORE_CLK_I,
    input wire logic        NRST_I,
    // Bus
    input wire logic        HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0]  HTRANS_I,
    input wire logic        HWRITE_I,
    input wire logic        HREADY_I,
    input wire logic [31:0] HRDATA_O,
    input wire logic        HREADYOUT_O,
    input wire logic        HRESP_O,
    // Link
    input wire logic        BIT_CLK_I,
    input wire logic        TX_DATA_O
);
    // ****************************************
    // Read data phase tracking
    // ****************************************
    logic       rd_ph_reg, rd_ph_next;
    logic [7:0] addr_reg, addr_next;
    logic       taken;
    always_comb begin
        taken      = HSEL_I && HREADY_I && HTRANS_I[1];
        rd_ph_next = taken && !HWRITE_I;
        addr_next  = taken ? HADDR_I[7:0] : addr_reg;
    end
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            rd_ph_reg <= 1'b0;
            addr_reg  <= 8'h00;
        end else begin
            rd_ph_reg <= rd_ph_next;
            addr_reg  <= addr_next;
        end
    end
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!NRST_I);
    a_ready_always: assert property (HREADYOUT_O == 1'b1) else $error("wait state seen");
    a_resp_okay: assert property (HRESP_O == 1'b0) else $error("error response seen");
    a_rdata_idle_zero: assert property (!rd_ph_reg |-> HRDATA_O == 32'h0)
        else $error("read data outside data phase");
    a_port_reads_zero: assert property (
        rd_ph_reg && addr_reg == atwf_pkg::DATA_PORT_OFFSET |-> HRDATA_O == 32'h0)
        else $error("data port read not zero");
    a_fmt_reserved_zero: assert property (
        rd_ph_reg && addr_reg == atwf_pkg::WORD_FORMAT_OFFSET
        |-> (HRDATA_O & ~atwf_pkg::WORD_FORMAT_MASK) == 32'h0)
        else $error("reserved set");
    a_unmapped_zero: assert property (rd_ph_reg && !(addr_reg inside {8'h00, 8'h04, 8'h14,
        8'h20}) |-> HRDATA_O == 32'h0) else $error("unmapped read not zero");
    a_fifo_flags_match: assert property (
        rd_ph_reg && addr_reg == atwf_pkg::STATUS_OFFSET
        |-> HRDATA_O[3:0] <= DEPTH && HRDATA_O[9] == (HRDATA_O[3:0] == DEPTH)
        && HRDATA_O[8] == (HRDATA_O[3:0] == 4'h0)) else $error("fifo flags wrong");
    a_tx_after_fall: assert property (
        $changed(TX_DATA_O) |-> !$past(BIT_CLK_I, 2) || !$past(BIT_CLK_I, 3))
        else $error("bit not after fall");
    c_port_read: cover property (rd_ph_reg && addr_reg == atwf_pkg::DATA_PORT_OFFSET);
    c_fifo_full: cover property (rd_ph_reg && HRDATA_O[9] && addr_reg == 8'h04);
    c_tx_high: cover property ($rose(TX_DATA_O));
endmodule : atwf_props
bind atwf_top atwf_props #(.DEPTH(DEPTH)) props_u (
    .CORE_CLK_I(CORE_CLK_I), .NRST_I(NRST_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I),
    .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HREADY_I(HREADY_I), .HRDATA_O(HRDATA_O),
    .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O), .BIT_CLK_I(BIT_CLK_I),
    .TX_DATA_O(TX_DATA_O));

// File: dv/atwf_codec_model.sv
`timescale 1ns/10ps
module atwf_codec_model (
    // Serial link
    output logic      bit_clk_o,
    output logic      frame_sync_o,
    input  wire logic tx_data_i
);
    logic [31:0] cap;
    initial begin
        bit_clk_o    = 1'b1;
        frame_sync_o = 1'b0;
        cap          = 32'h0;
    end
    // ****************************************
    // One frame, clock stands high outside it
    // ****************************************
    // Capture late in the bit: output lags each fall by up to three core cycles
    task automatic run_frame(input int n);
        cap = 32'h0;
        #7 bit_clk_o = 1'b0;
        #160 bit_clk_o = 1'b1;
        frame_sync_o = 1'b1;
        #160;
        for (int i = 0; i < n; i++) begin
            bit_clk_o = 1'b0;
            #160 bit_clk_o = 1'b1;
            frame_sync_o = 1'b0;
            #159 cap = {cap[30:0], tx_data_i};
            #1;
        end
        bit_clk_o = 1'b0;
        #160 bit_clk_o = 1'b1;
        #160;
    endtask : run_frame
endmodule : atwf_codec_model

// File: dv/audio_tx_word_format_fifo_port_bench.sv
`timescale 1ns/10ps
module audio_tx_word_format_fifo_port_bench;
    logic clk, nrst, hsel, hwrite, hready, hreadyout, hresp, bclk, fsync, txd;
    logic [31:0] haddr, hwdata, hrdata, rd_v, exp_v, hr_s;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        hready_s;
    int          err_total, check_count;
    logic [31:0] data [5] = '{32'ha5c31e69, 32'h3c96f0e1, 32'h12345678, 32'h0f1e2d3c,
                              32'h77aa55cc};
    assign hready = hreadyout;
    atwf_top #(.DEPTH(4)) dut_u (
        .CORE_CLK_I(clk), .NRST_I(nrst), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
        .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hready),
        .HRDATA_O(hrdata), .HREADYOUT_O(hreadyout), .HRESP_O(hresp), .BIT_CLK_I(bclk),
        .FRAME_SYNC_I(fsync), .TX_DATA_O(txd));
    atwf_codec_model codec_u (.bit_clk_o(bclk), .frame_sync_o(fsync), .tx_data_i(txd));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Bus values settled mid-cycle, taken at the following edge
    always @(negedge clk) begin
        hr_s     = hrdata;
        hready_s = hready;
    end
    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        check_count++;
        if (seen !== want) begin
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
            err_total++;
        end
    endtask : check
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= atwf_pkg::HTRANS_NONSEQ;
        haddr  <= {24'h0, a};
        hwrite <= w;
        @(posedge clk);
        while (hready_s !== 1'b1) @(posedge clk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk);
        while (hready_s !== 1'b1) @(posedge clk);
        rd_v = hr_s;
    endtask : bus
    task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] want);
        bus(1'b0, a, 32'h0);
        check(rd_v & m, want);
    endtask : rdm
    function automatic logic [31:0] bits(logic [31:0] w, logic [4:0] first_bit_index, int n, logic msb);
        logic [31:0] o;
        logic [4:0]  ix;
        o = 32'h0;
        for (int k = 0; k < n; k++) begin
            ix = msb ? first_bit_index - 5'(k) : first_bit_index + 5'(k);
            o  = {o[30:0], w[ix]};
        end
        return o;
    endfunction : bits
    task automatic tally_and_finish();
        if (err_total == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish
    initial begin
        #300000;
        err_total++;
        tally_and_finish();
    end
    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        err_total = 0;
        check_count = 0;
        nrst = 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        rdm(8'h14, 32'hffffffff, 32'h0);
        bus(1'b1, 8'h14, 32'hffffffff);
        rdm(8'h14, 32'hffffffff, 32'h1f1f1f00);
        bus(1'b1, 8'h40, 32'h5);
        rdm(8'h40, 32'hffffffff, 32'h0);
        bus(1'b1, 8'h20, 32'hdeadbeef);
        rdm(8'h04, 32'h30f, 32'h100);
        bus(1'b1, 8'h00, 32'h2);
        for (int i = 0; i < 5; i++) bus(1'b1, 8'h20, data[i]);
        rdm(8'h04, 32'h30f, 32'h204);
        rdm(8'h20, 32'hffffffff, 32'h0);
        // Later 16 bits, first 8 bits, index 16, MSB first, two words
        bus(1'b1, 8'h14, 32'h0f071000);
        bus(1'b1, 8'h00, 32'h00010013);
        codec_u.run_frame(24);
        exp_v = (bits(data[0], 5'd16, 8, 1'b1) << 16) | bits(data[1], 5'd16, 16, 1'b1);
        check(codec_u.cap, exp_v);
        // Two entries left, second slot reached, index stepped down to 1
        rdm(8'h04, 32'h001f0f0f, 32'h00010802);
        bus(1'b1, 8'h00, 32'h2);
        bus(1'b1, 8'h14, 32'h070b0300);
        bus(1'b1, 8'h00, 32'h3);
        // Fifth write was dropped, so the last frame underruns to zeros
        for (int i = 2; i < 5; i++) begin
            codec_u.run_frame(12);
            exp_v = bits(i < 4 ? data[i] : 32'h0, 5'd3, 12, 1'b0);
            check(codec_u.cap, exp_v);
        end
        rdm(8'h04, 32'h30f, 32'h100);
        tally_and_finish();
    end
endmodule : audio_tx_word_format_fifo_port_bench
